// file: pdpr_regs.svh
// Register indices, field masks, reset values and timing counts.
`ifndef PDPR_REGS_SVH
`define PDPR_REGS_SVH

`define PDPR_IDX_P0_PULLUP 10'h0a4
`define PDPR_IDX_P1_PULLUP 10'h0a5
`define PDPR_IDX_P2_PULLUP 10'h0a6
`define PDPR_IDX_P6_DIR 10'h0be
`define PDPR_IDX_P7_DIR 10'h0bf
`define PDPR_IDX_P6_LEVEL 10'h3e0
`define PDPR_IDX_P7_LEVEL 10'h3e1

`define PDPR_P2_PULLUP_LSB 4
`define PDPR_P2_PULLUP_MSB 7

`define PDPR_RST_DIR 8'hff
`define PDPR_RST_PULLUP 8'h00
`define PDPR_RST_P2_PULLUP 4'h0

`define PDPR_SYNC_STAGES 2

`endif

// file: pdpr_pkg.sv
// Types shared by the port direction and pull-up register block.
package pdpr_pkg;

  typedef logic [7:0] pdpr_byte_t;

  typedef enum logic [2:0] {
    PDPR_SEL_NONE = 3'b000,
    PDPR_SEL_P0_PU = 3'b001,
    PDPR_SEL_P1_PU = 3'b010,
    PDPR_SEL_P2_PU = 3'b011,
    PDPR_SEL_P6_DIR = 3'b100,
    PDPR_SEL_P7_DIR = 3'b101,
    PDPR_SEL_P6_LVL = 3'b110,
    PDPR_SEL_P7_LVL = 3'b111
  } pdpr_sel_t;

endpackage

// file: pdpr_pad_if.sv
// Signals between the register bank and one port's pad control.
`timescale 1ns/1ps
interface pdpr_pad_if #(
  parameter int PORT_W = 8
);
  logic [PORT_W-1:0] dir;
  logic [PORT_W-1:0] latch;
  logic [PORT_W-1:0] pin_in;
  logic [PORT_W-1:0] pin_out;
  logic [PORT_W-1:0] pin_oe;
  logic [PORT_W-1:0] level;

  modport ctrl (
    input dir,
    input latch,
    input pin_in,
    output pin_out,
    output pin_oe,
    output level
  );

  modport bank (
    output dir,
    output latch,
    output pin_in,
    input pin_out,
    input pin_oe,
    input level
  );
endinterface

// file: pdpr_pad_ctrl.sv
// Pad driver and input synchroniser for one direction-controlled port.
`timescale 1ns/1ps
`include "pdpr_regs.svh"
module pdpr_pad_ctrl
  import pdpr_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int SYNC_STAGES = `PDPR_SYNC_STAGES
) (
  input wire logic pclk,
  input wire logic presetn,
  pdpr_pad_if.ctrl pad
);

  generate
    if (PORT_W < 1 || SYNC_STAGES < 2) begin : g_bad_params
      $error("pdpr_pad_ctrl: bad PORT_W or SYNC_STAGES");
    end
  endgenerate

  logic [PORT_W-1:0] sync_q [SYNC_STAGES];
  logic [PORT_W-1:0] pin_out_q;
  logic [PORT_W-1:0] pin_oe_q;

  // A 1 in the direction bit releases the pad; a 0 drives the latch value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
    end else begin
      pin_out_q <= pad.latch;
      pin_oe_q <= ~pad.dir;
    end
  end

  // Each stage but the last is read only by the next stage; the last drives pad.level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_q[i] <= '0;
      end
    end else begin
      sync_q[0] <= pad.pin_in;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_q[i] <= sync_q[i-1];
      end
    end
  end

  assign pad.pin_out = pin_out_q;
  assign pad.pin_oe = pin_oe_q;
  assign pad.level = sync_q[SYNC_STAGES-1];

  AST_PAD_OE_FOLLOWS_DIR: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 pad.pin_oe == ~$past(pad.dir))
    else $error("pad enable does not follow direction");

  AST_PAD_OUT_FOLLOWS_LATCH: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 $past(presetn) |-> pad.pin_out == $past(pad.latch))
    else $error("pad output does not follow port latch");

endmodule

// file: pdpr_top.sv
// APB register bank for port 6/7 direction, port 0/1 pull-ups and port 2 bit 7 to 4 pull-ups.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "pdpr_regs.svh"
module pdpr_top
  import pdpr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int PORT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PORT_W-1:0] p6_pin_i,
  output logic [PORT_W-1:0] p6_pin_o,
  output logic [PORT_W-1:0] p6_pin_oe,
  input wire logic [PORT_W-1:0] p6_latch,
  output logic [PORT_W-1:0] p6_level,
  input wire logic [PORT_W-1:0] p7_pin_i,
  output logic [PORT_W-1:0] p7_pin_o,
  output logic [PORT_W-1:0] p7_pin_oe,
  input wire logic [PORT_W-1:0] p7_latch,
  output logic [PORT_W-1:0] p7_level,
  output logic [7:0] p0_pullup_en,
  output logic [7:0] p1_pullup_en,
  output logic [3:0] p2_hi_pullup_en
);

  generate
    if (ADDR_W < 12 || PORT_W != 8) begin : g_bad_params
      $error("pdpr_top: ADDR_W must be 12 or more and PORT_W 8");
    end
  endgenerate

  localparam int NPORT = 2;

  // Register state.
  pdpr_byte_t port6_direction_q;
  pdpr_byte_t port6_direction_d;
  pdpr_byte_t port7_direction_q;
  pdpr_byte_t port7_direction_d;
  pdpr_byte_t port0_pullup_enable_q;
  pdpr_byte_t port0_pullup_enable_d;
  pdpr_byte_t port1_pullup_enable_q;
  pdpr_byte_t port1_pullup_enable_d;
  logic [3:0] port2_pullup_enable_q;
  logic [3:0] port2_pullup_enable_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  // Address decode.
  wire [9:0] word_idx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire upper_zero;
  pdpr_sel_t sel;

  generate
    if (ADDR_W > 12) begin : g_upper
      assign upper_zero = (paddr[ADDR_W-1:12] == '0);
    end else begin : g_no_upper
      assign upper_zero = 1'b1;
    end
  endgenerate

  wire addr_ok = aligned && upper_zero;

  assign sel = !addr_ok ? PDPR_SEL_NONE :
    (word_idx == `PDPR_IDX_P0_PULLUP) ? PDPR_SEL_P0_PU :
    (word_idx == `PDPR_IDX_P1_PULLUP) ? PDPR_SEL_P1_PU :
    (word_idx == `PDPR_IDX_P2_PULLUP) ? PDPR_SEL_P2_PU :
    (word_idx == `PDPR_IDX_P6_DIR) ? PDPR_SEL_P6_DIR :
    (word_idx == `PDPR_IDX_P7_DIR) ? PDPR_SEL_P7_DIR :
    (word_idx == `PDPR_IDX_P6_LEVEL) ? PDPR_SEL_P6_LVL :
    (word_idx == `PDPR_IDX_P7_LEVEL) ? PDPR_SEL_P7_LVL :
    PDPR_SEL_NONE;

  wire is_mapped = (sel != PDPR_SEL_NONE);
  wire is_read_only = (sel == PDPR_SEL_P6_LVL) || (sel == PDPR_SEL_P7_LVL);
  wire bad_access = !is_mapped || (pwrite && is_read_only);

  // The slave answers with no wait states.
  assign pready = 1'b1;

  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable && pready;
  // A write counts only when the low byte lane is strobed.
  wire byte_wr = access_ph && pwrite && pstrb[0];
  wire wr_p0 = byte_wr && (sel == PDPR_SEL_P0_PU);
  wire wr_p1 = byte_wr && (sel == PDPR_SEL_P1_PU);
  wire wr_p2 = byte_wr && (sel == PDPR_SEL_P2_PU);
  wire wr_p6 = byte_wr && (sel == PDPR_SEL_P6_DIR);
  wire wr_p7 = byte_wr && (sel == PDPR_SEL_P7_DIR);

  assign port0_pullup_enable_d =
    wr_p0 ? pwdata[7:0] : port0_pullup_enable_q;
  assign port1_pullup_enable_d =
    wr_p1 ? pwdata[7:0] : port1_pullup_enable_q;
  // Bits 3 to 0 of the written byte are dropped here.
  assign port2_pullup_enable_d = wr_p2 ?
    pwdata[`PDPR_P2_PULLUP_MSB:`PDPR_P2_PULLUP_LSB] :
    port2_pullup_enable_q;
  assign port6_direction_d =
    wr_p6 ? pwdata[7:0] : port6_direction_q;
  assign port7_direction_d =
    wr_p7 ? pwdata[7:0] : port7_direction_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_pullup_enable_q <= `PDPR_RST_PULLUP;
      port1_pullup_enable_q <= `PDPR_RST_PULLUP;
      port2_pullup_enable_q <= `PDPR_RST_P2_PULLUP;
      port6_direction_q <= `PDPR_RST_DIR;
      port7_direction_q <= `PDPR_RST_DIR;
    end else begin
      port0_pullup_enable_q <= port0_pullup_enable_d;
      port1_pullup_enable_q <= port1_pullup_enable_d;
      port2_pullup_enable_q <= port2_pullup_enable_d;
      port6_direction_q <= port6_direction_d;
      port7_direction_q <= port7_direction_d;
    end
  end

  // Read data and the error flag are captured in the setup cycle.
  pdpr_byte_t rd_byte;
  pdpr_byte_t p2_read;

  assign p2_read = {port2_pullup_enable_q, 4'h0};

  always_comb begin
    rd_byte = 8'h00;
    case (sel)
      PDPR_SEL_P0_PU: rd_byte = port0_pullup_enable_q;
      PDPR_SEL_P1_PU: rd_byte = port1_pullup_enable_q;
      PDPR_SEL_P2_PU: rd_byte = p2_read;
      PDPR_SEL_P6_DIR: rd_byte = port6_direction_q;
      PDPR_SEL_P7_DIR: rd_byte = port7_direction_q;
      PDPR_SEL_P6_LVL: rd_byte = p6_level;
      PDPR_SEL_P7_LVL: rd_byte = p7_level;
      default: rd_byte = 8'h00;
    endcase
  end

  assign prdata_d = setup_ph ?
    ((!pwrite && !bad_access) ? {24'h000000, rd_byte} : 32'h00000000) :
    prdata_q;
  assign pslverr_d = setup_ph ? bad_access : pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  assign p0_pullup_en = port0_pullup_enable_q;
  assign p1_pullup_en = port1_pullup_enable_q;
  assign p2_hi_pullup_en = port2_pullup_enable_q;

  // Per-port pad control for the two direction-controlled ports.
  logic [PORT_W-1:0] dir_a [NPORT];
  logic [PORT_W-1:0] latch_a [NPORT];
  logic [PORT_W-1:0] pin_in_a [NPORT];
  logic [PORT_W-1:0] pin_out_a [NPORT];
  logic [PORT_W-1:0] pin_oe_a [NPORT];
  logic [PORT_W-1:0] level_a [NPORT];

  assign dir_a[0] = port6_direction_q;
  assign dir_a[1] = port7_direction_q;
  assign latch_a[0] = p6_latch;
  assign latch_a[1] = p7_latch;
  assign pin_in_a[0] = p6_pin_i;
  assign pin_in_a[1] = p7_pin_i;

  generate
    for (genvar g = 0; g < NPORT; g++) begin : g_port
      pdpr_pad_if #(.PORT_W(PORT_W)) pad ();

      assign pad.dir = dir_a[g];
      assign pad.latch = latch_a[g];
      assign pad.pin_in = pin_in_a[g];
      assign pin_out_a[g] = pad.pin_out;
      assign pin_oe_a[g] = pad.pin_oe;
      assign level_a[g] = pad.level;

      pdpr_pad_ctrl #(
        .PORT_W(PORT_W),
        .SYNC_STAGES(`PDPR_SYNC_STAGES)
      ) u_pad (
        .pclk(pclk),
        .presetn(presetn),
        .pad(pad)
      );
    end
  endgenerate

  assign p6_pin_o = pin_out_a[0];
  assign p6_pin_oe = pin_oe_a[0];
  assign p6_level = level_a[0];
  assign p7_pin_o = pin_out_a[1];
  assign p7_pin_oe = pin_oe_a[1];
  assign p7_level = level_a[1];

  // Checks on the register bank.
  sequence s_wr(pdpr_sel_t s);
    psel && penable && pwrite && pstrb[0] && (sel == s);
  endsequence

  sequence s_rd_setup(pdpr_sel_t s);
    psel && !penable && !pwrite && (sel == s);
  endsequence

  AST_P6_DIR_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(PDPR_SEL_P6_DIR) |=> port6_direction_q == $past(pwdata[7:0]))
    else $error("port 6 direction write lost");

  AST_P6_INPUT_MODE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(PDPR_SEL_P6_DIR) |=> ##1 p6_pin_oe == ~$past(pwdata[7:0], 2))
    else $error("port 6 pad enable wrong after direction write");

  AST_P7_DIR_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(PDPR_SEL_P7_DIR) |=> ##1 p7_pin_oe == ~$past(pwdata[7:0], 2))
    else $error("port 7 pad enable wrong after direction write");

  AST_P0_PU_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(PDPR_SEL_P0_PU) |=> p0_pullup_en == $past(pwdata[7:0]))
    else $error("port 0 pull-up write lost");

  AST_P1_PU_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(PDPR_SEL_P1_PU) |=> p1_pullup_en == $past(pwdata[7:0]))
    else $error("port 1 pull-up write lost");

  AST_P2_PU_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(PDPR_SEL_P2_PU) |=> p2_hi_pullup_en == $past(pwdata[7:4]))
    else $error("port 2 pull-up write lost");

  AST_P2_LOW_READS_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_rd_setup(PDPR_SEL_P2_PU) ##1 penable |->
      prdata[3:0] == 4'h0 && prdata[7:4] == $past(p2_hi_pullup_en))
    else $error("port 2 read shows unused bits");

  AST_NO_LANE_NO_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_ph && pwrite && !pstrb[0]) |=>
      $stable(port6_direction_q) && $stable(port7_direction_q) &&
      $stable(port0_pullup_enable_q) && $stable(p2_hi_pullup_en) &&
      $stable(port1_pullup_enable_q))
    else $error("register changed without low byte strobe");

  AST_PU_HOLDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !byte_wr |=> $stable(p0_pullup_en) && $stable(p1_pullup_en))
    else $error("pull-up enable changed without a write");

  AST_UNMAPPED_ERROR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !is_mapped) ##1 penable |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");

  AST_P7_DIR_REG_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(PDPR_SEL_P7_DIR) |=> port7_direction_q == $past(pwdata[7:0]))
    else $error("port 7 direction write lost");

  AST_MISALIGNED_ERROR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && paddr[1:0] != 2'b00) ##1 penable |->
      pslverr && prdata == 32'h00000000)
    else $error("misaligned access not refused");

  AST_LEVEL_WRITE_REFUSED: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && pwrite && is_read_only) ##1 penable |-> pslverr)
    else $error("write to a pin level register not refused");

  AST_READ_HIGH_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite) |-> prdata[31:8] == 24'h000000)
    else $error("read data above the low byte not zero");

endmodule

// file: pdpr_pin_model.sv
// Port pins with pad drivers and an outside source on input pins.
`timescale 1ns/1ps
module pdpr_pin_model (
  input wire logic clk,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin
);
  logic [7:0] float_q = 8'h5a;
  // A pin nobody drives wanders, so a stale level never looks valid.
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  // The pad driver wins while enabled, else the outside source.
  assign pin = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) |
               (~pin_oe & ~ext_en & float_q);
endmodule

// file: tb.sv
// Self-checking bench for the port direction and pull-up registers.
`timescale 1ns/1ps
`include "pdpr_regs.svh"
module tb;
  import pdpr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] l6 = 8'h00, l7 = 8'h00, x6 = 8'h00, x7 = 8'h00;
  logic [7:0] e6 = 8'hff, e7 = 8'hff;
  logic [7:0] i6, o6, oe6, lv6, i7, o7, oe7, lv7, pu0, pu1;
  logic [3:0] pu2;
  logic [31:0] rd;
  logic err;
  int err_count = 0;
  int cmp_count = 0;
  logic [9:0] idx_t[5] = '{`PDPR_IDX_P0_PULLUP, `PDPR_IDX_P1_PULLUP,
    `PDPR_IDX_P2_PULLUP, `PDPR_IDX_P6_DIR, `PDPR_IDX_P7_DIR};
  logic [7:0] msk_t[5] = '{8'hff, 8'hff, 8'hf0, 8'hff, 8'hff};
  logic [7:0] rst_t[5] = '{`PDPR_RST_PULLUP, `PDPR_RST_PULLUP,
    `PDPR_RST_PULLUP, `PDPR_RST_DIR, `PDPR_RST_DIR};

  always #5 pclk = ~pclk;

  pdpr_top i_pdpr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p6_pin_i(i6), .p6_pin_o(o6), .p6_pin_oe(oe6), .p6_latch(l6),
    .p6_level(lv6), .p7_pin_i(i7), .p7_pin_o(o7), .p7_pin_oe(oe7),
    .p7_latch(l7), .p7_level(lv7), .p0_pullup_en(pu0),
    .p1_pullup_en(pu1), .p2_hi_pullup_en(pu2));
  pdpr_pin_model i_pdpr_pin_model_6 (.clk(pclk), .pin_o(o6),
    .pin_oe(oe6), .ext_val(x6), .ext_en(e6), .pin(i6));
  pdpr_pin_model i_pdpr_pin_model_7 (.clk(pclk), .pin_o(o7),
    .pin_oe(oe7), .ext_val(x7), .ext_en(e7), .pin(i7));

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [9:0] ix, input logic [1:0] lo,
      input logic [7:0] d, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, lo};
    pwdata <= {24'hc3a5f0, d};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      chk("pready", 32'h1, 32'h0);
    end
  endtask

  task automatic rdchk(input logic [9:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 2'b00, 8'h00, 4'hf);
    chk("prdata", {24'h0, e}, rd);
    chk("pslverr", 32'h0, {31'h0, err});
  endtask

  task automatic test_reset;
    for (int i = 0; i < 5; i++) begin
      rdchk(idx_t[i], rst_t[i]);
    end
    chk("p6_pin_oe", 32'h0, {24'h0, oe6});
    chk("pullups", 32'h0, {12'h0, pu0, pu1, pu2});
  endtask

  task automatic test_rw;
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'ha5 : 8'h5a;
      for (int i = 0; i < 5; i++) begin
        apb(1'b1, idx_t[i], 2'b00, d, 4'hf);
        rdchk(idx_t[i], d & msk_t[i]);
      end
      repeat (2) @(posedge pclk);
      chk("p0_pullup_en", {24'h0, d}, {24'h0, pu0});
      chk("p1_pullup_en", {24'h0, d}, {24'h0, pu1});
      chk("p2_hi_pullup_en", {28'h0, d[7:4]}, {28'h0, pu2});
      chk("p6_pin_oe", {24'h0, ~d}, {24'h0, oe6});
      chk("p7_pin_oe", {24'h0, ~d}, {24'h0, oe7});
    end
  endtask

  task automatic test_pins;
    apb(1'b1, `PDPR_IDX_P6_DIR, 2'b00, 8'h0f, 4'hf);
    apb(1'b1, `PDPR_IDX_P7_DIR, 2'b00, 8'hf0, 4'hf);
    l6 <= 8'hc3;
    l7 <= 8'h3c;
    x6 <= 8'h96;
    x7 <= 8'h69;
    e6 <= 8'h0f;
    e7 <= 8'hf0;
    repeat (5) @(posedge pclk);
    chk("p6_pin_o", 32'hc0, {24'h0, o6 & oe6});
    chk("p7_pin_o", 32'h0c, {24'h0, o7 & oe7});
    chk("p6_level", 32'hc6, {24'h0, lv6});
    chk("p7_level", 32'h6c, {24'h0, lv7});
    rdchk(`PDPR_IDX_P6_LEVEL, 8'hc6);
    rdchk(`PDPR_IDX_P7_LEVEL, 8'h6c);
  endtask

  task automatic test_refused;
    apb(1'b1, `PDPR_IDX_P0_PULLUP, 2'b00, 8'h3c, 4'hf);
    apb(1'b1, `PDPR_IDX_P0_PULLUP, 2'b00, 8'hc3, 4'he);
    rdchk(`PDPR_IDX_P0_PULLUP, 8'h3c);
    apb(1'b0, 10'h0a7, 2'b00, 8'h00, 4'hf);
    chk("unmapped pslverr", 32'h1, {31'h0, err});
    chk("unmapped prdata", 32'h0, rd);
    apb(1'b1, `PDPR_IDX_P1_PULLUP, 2'b10, 8'h81, 4'hf);
    chk("misaligned pslverr", 32'h1, {31'h0, err});
    apb(1'b1, `PDPR_IDX_P6_LEVEL, 2'b00, 8'h81, 4'hf);
    chk("level write pslverr", 32'h1, {31'h0, err});
    rdchk(`PDPR_IDX_P1_PULLUP, 8'ha5);
    rdchk(`PDPR_IDX_P6_DIR, 8'h0f);
  endtask

  // A reset in mid-run must bring every register back to its reset value.
  task automatic test_midreset;
    apb(1'b1, `PDPR_IDX_P0_PULLUP, 2'b00, 8'h77, 4'hf);
    apb(1'b1, `PDPR_IDX_P6_DIR, 2'b00, 8'h00, 4'hf);
    chk("p0_pullup_en", 32'h77, {24'h0, pu0});
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_reset;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset;
    test_rw;
    test_pins;
    test_refused;
    test_midreset;
    finish_test;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    finish_test;
  end
endmodule
